/* hw/cdu_config_loader.sv */
`timescale 1ns/10ps
module cdu_config_loader #(
  parameter int CFG_BYTES    = cdu_pkg::CFG_BYTES,
  parameter int SE_DELAY_CYC = cdu_pkg::SE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  // Supply
  input  wire logic                      supply_lockout_release_i,
  // Host link
  input  wire logic                      link_clk_i,
  input  wire logic                      link_sel_i,
  input  wire logic [7:0]                link_data_i,
  output logic                           link_ack_o,
  output logic      [7:0]                link_rdata_o,
  // Function side
  output logic      [CFG_BYTES*8-1:0]    cfg_live_o,
  output logic                           load_done_o,
  // Sequencing engine
  input  wire logic                      se_advance_i,
  input  wire logic [5:0]                se_next_i,
  output logic      [63:0]               se_word_o,
  output logic                           se_load_o
);
  import cdu_pkg::*;

  function automatic logic cdu_in_nv(input logic [7:0] hi);
    return (hi >= NV_HI_FIRST) && (hi <= NV_HI_LAST);
  endfunction

  function automatic logic cdu_is_special(input logic [7:0] lo);
    return (lo == ADDR_RELOAD) || (lo == ADDR_PTR_HI) ||
           (lo == ADDR_ERASE) || (lo == ADDR_STATUS) ||
           (lo == ADDR_UPD_CTRL);
  endfunction

  // Synchronisers: lockout, link clock, link select, link data
  logic [2:0]    s1_q;
  logic [2:0]    s2_q;
  logic [7:0]    d1_q;
  logic [7:0]    d2_q;
  logic          lclk_q;

  logic [7:0]    latch_a [CFG_BYTES];
  logic [7:0]    latch_b [CFG_BYTES];
  logic [7:0]    upd_ctrl_q;
  logic          commit_q;
  logic          reload_req_q;
  logic [7:0]    ptr_hi_q;
  logic [7:0]    ptr_lo_q;
  logic          first_q;
  logic          done_q;
  cdu_state_type state_q;
  logic [7:0]    idx_q;
  logic          pend_q;
  logic [7:0]    pidx_q;
  logic [3:0]    bcnt_q;
  logic [13:0]   tmr_q;
  logic [5:0]    se_idx_q;
  logic [63:0]   se_buf_q;
  logic [7:0]    nv_rdata;
  logic          erase_q;
  logic [4:0]    erase_page_q;

  // Byte strobe on a rising link clock inside a selected frame
  wire       byte_stb  = s2_q[1] & ~lclk_q & s2_q[2];
  wire       wr_stb    = byte_stb & ~first_q & done_q;
  wire       ptr_nv    = cdu_in_nv(ptr_hi_q);
  wire [9:0] host_nv   = {ptr_hi_q[1:0], ptr_lo_q};
  wire       wr_reg    = wr_stb & ~ptr_nv;
  wire       cfg_wr    = wr_reg & (ptr_lo_q < 8'(CFG_BYTES)) &
                         ~cdu_is_special(ptr_lo_q);
  wire       upd_wr    = wr_reg & (ptr_lo_q == ADDR_UPD_CTRL);
  wire       host_cmt  = upd_wr & d2_q[UPD_COMMIT_BIT];
  wire       reload_wr = wr_reg & (ptr_lo_q == ADDR_RELOAD) &
                         d2_q[RELOAD_BIT];
  wire       erase_wr  = wr_reg & (ptr_lo_q == ADDR_ERASE) &
                         upd_ctrl_q[UPD_ERASE_BIT];
  wire       live      = upd_ctrl_q[UPD_LIVE_BIT];
  wire       in_load   = (state_q == ST_LOAD);
  wire       in_fetch  = (state_q == ST_FETCH);
  wire       all_b     = (state_q == ST_COMMIT) | commit_q;
  wire       load_end  = in_load & (idx_q == 8'(CFG_BYTES)) & ~pend_q;
  wire       fetch_end = in_fetch & (tmr_q == 14'(SE_FETCH_CYC - 1));
  wire       wait_end  = (state_q == ST_SE_WAIT) &
                         (tmr_q == 14'(SE_DELAY_CYC - 1));
  wire [9:0] se_addr   = {1'b1, se_idx_q, bcnt_q[2:0]};
  wire [9:0] nv_raddr  = in_load  ? {2'b00, idx_q} :
                         in_fetch ? se_addr : host_nv;
  wire [7:0] upd_view  = {5'h00, upd_ctrl_q[UPD_ERASE_BIT], commit_q,
                          upd_ctrl_q[UPD_LIVE_BIT]};
  wire [7:0] reg_rdata = (ptr_lo_q == ADDR_UPD_CTRL) ? upd_view :
                         (ptr_lo_q == ADDR_PTR_HI) ? ptr_hi_q :
                         (ptr_lo_q == ADDR_STATUS) ? {7'h00, done_q} :
                         cdu_is_special(ptr_lo_q) ? 8'h00 :
                         (ptr_lo_q < 8'(CFG_BYTES)) ? latch_a[ptr_lo_q] :
                         8'h00;
  wire [7:0] rdata_d   = ptr_nv ? nv_rdata : reg_rdata;

  cdu_nv_store u_nv (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .rd_addr_i    (nv_raddr),
    .rd_data_o    (nv_rdata),
    .wr_en_i      (wr_stb & ptr_nv),
    .wr_addr_i    (host_nv),
    .wr_data_i    (d2_q),
    .erase_i      (erase_q),
    .erase_page_i (erase_page_q)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      d1_q   <= 8'h00;
      d2_q   <= 8'h00;
      lclk_q <= 1'b0;
    end else begin
      s1_q   <= {link_sel_i, link_clk_i, supply_lockout_release_i};
      s2_q   <= s1_q;
      d1_q   <= link_data_i;
      d2_q   <= d1_q;
      lclk_q <= s2_q[1];
    end
  end

  // Host link: pointer, answers and control registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_q      <= 1'b1;
      ptr_lo_q     <= 8'h00;
      ptr_hi_q     <= PTR_HI_RESET;
      link_ack_o   <= 1'b0;
      link_rdata_o <= 8'h00;
      upd_ctrl_q   <= UPD_CTRL_RESET;
      commit_q     <= 1'b0;
      erase_q      <= 1'b0;
      erase_page_q <= 5'h00;
    end else begin
      link_rdata_o <= rdata_d;
      commit_q     <= host_cmt;
      erase_q      <= erase_wr;
      if (erase_wr) begin
        erase_page_q <= {ptr_hi_q[1:0] == 2'b00 ? 1'b0 : 1'b1,
                         d2_q[3:0]};
      end
      if (!s2_q[2]) begin
        first_q <= 1'b1;
      end else if (byte_stb && done_q) begin
        first_q <= 1'b0;
      end
      if (byte_stb) begin
        link_ack_o <= done_q;
      end
      if (byte_stb && first_q && done_q) begin
        ptr_lo_q <= d2_q;
      end else if (wr_stb) begin
        ptr_lo_q <= ptr_lo_q + 8'h01;
      end
      if (wr_reg && ptr_lo_q == ADDR_PTR_HI) begin
        ptr_hi_q <= d2_q;
      end
      if (upd_wr) begin
        upd_ctrl_q <= {5'h00, d2_q[UPD_ERASE_BIT], 1'b0,
                       d2_q[UPD_LIVE_BIT]};
      end
    end
  end

  // Reload request is held until the loader takes it; a new one wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload_req_q <= 1'b0;
    end else begin
      reload_req_q <= reload_wr |
                      (reload_req_q & ~(state_q == ST_RUN));
    end
  end

  // Double-buffered configuration latches
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        latch_a[i] <= 8'h00;
        latch_b[i] <= 8'h00;
      end
    end else begin
      if (in_load && pend_q) begin
        latch_a[pidx_q] <= nv_rdata;
      end else if (cfg_wr) begin
        latch_a[ptr_lo_q] <= d2_q;
      end
      if (all_b) begin
        for (int i = 0; i < CFG_BYTES; i++) begin
          latch_b[i] <= latch_a[i];
        end
      end else if (cfg_wr && live) begin
        latch_b[ptr_lo_q] <= d2_q;
      end
    end
  end

  // Load and fetch sequence
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q  <= ST_LOCKOUT;
      done_q   <= 1'b0;
      idx_q    <= 8'h00;
      pend_q   <= 1'b0;
      pidx_q   <= 8'h00;
      bcnt_q   <= 4'h0;
      tmr_q    <= 14'h0000;
      se_idx_q <= 6'h00;
      se_buf_q <= 64'h0;
      se_word_o <= 64'h0;
      se_load_o <= 1'b0;
    end else begin
      se_load_o <= 1'b0;
      pend_q    <= 1'b0;
      tmr_q     <= tmr_q + 14'h0001;
      case (state_q)
        ST_LOCKOUT: begin
          idx_q <= 8'h00;
          if (s2_q[0]) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (idx_q != 8'(CFG_BYTES)) begin
            pend_q <= 1'b1;
            pidx_q <= idx_q;
            idx_q  <= idx_q + 8'h01;
          end
          if (load_end) begin
            state_q <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          tmr_q   <= 14'h0000;
          done_q  <= 1'b1;
          state_q <= done_q ? ST_RUN : ST_SE_WAIT;
        end
        ST_SE_WAIT: begin
          se_idx_q <= 6'h00;
          bcnt_q   <= 4'h0;
          if (wait_end) begin
            tmr_q   <= 14'h0000;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (bcnt_q != 4'h8) begin
            bcnt_q <= bcnt_q + 4'h1;
          end
          if (bcnt_q != 4'h0 && tmr_q <= 14'h0008) begin
            se_buf_q <= {nv_rdata, se_buf_q[63:8]};
          end
          if (fetch_end) begin
            se_word_o <= se_buf_q;
            se_load_o <= 1'b1;
            state_q   <= ST_RUN;
          end
        end
        ST_RUN: begin
          idx_q  <= 8'h00;
          bcnt_q <= 4'h0;
          tmr_q  <= 14'h0000;
          if (reload_req_q) begin
            state_q <= ST_LOAD;
          end else if (se_advance_i) begin
            se_idx_q <= se_next_i;
            state_q  <= ST_FETCH;
          end
        end
        default: begin
          state_q <= ST_LOCKOUT;
        end
      endcase
    end
  end

  assign load_done_o = done_q;

  // Stage B latches drive the functions directly
  for (genvar g = 0; g < CFG_BYTES; g++) begin : g_live
    assign cfg_live_o[g*8 +: 8] = latch_b[g];
  end
endmodule

/* hw/cdu_nv_store.sv */
`timescale 1ns/10ps
module cdu_nv_store #(
  parameter int NV_BYTES   = cdu_pkg::NV_BYTES,
  parameter int PAGE_BYTES = cdu_pkg::PAGE_BYTES
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // Read port
  input  wire logic [9:0]          rd_addr_i,
  output logic      [7:0]          rd_data_o,
  // Write and erase
  input  wire logic                wr_en_i,
  input  wire logic [9:0]          wr_addr_i,
  input  wire logic [7:0]          wr_data_i,
  input  wire logic                erase_i,
  input  wire logic [4:0]          erase_page_i
);
  import cdu_pkg::*;
  // Contents survive reset, as nonvolatile cells would
  logic [7:0] mem [NV_BYTES];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
  // A write can only clear bits; a used cell needs an erase first
  always_ff @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[{erase_page_i, 5'(i)}] <= 8'hff;
      end
    end else if (wr_en_i) begin
      mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
    end
  end
endmodule

/* hw/cdu_pkg.sv */
package cdu_pkg;
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          PAGE_BYTES     = 32;
  localparam int          CFG_PAGES      = 7;
  localparam int          CFG_BYTES      = PAGE_BYTES * CFG_PAGES;
  localparam int          NV_BYTES       = 1024;
  localparam int          SE_STATES      = 64;
  localparam int          SE_WORD_BITS   = 64;
  localparam logic [7:0]  ADDR_RELOAD    = 8'hd8;
  localparam logic [7:0]  ADDR_PTR_HI    = 8'he0;
  localparam logic [7:0]  ADDR_ERASE     = 8'he1;
  localparam logic [7:0]  ADDR_STATUS    = 8'he2;
  localparam logic [7:0]  ADDR_UPD_CTRL  = 8'he3;
  localparam logic [7:0]  NV_HI_FIRST    = 8'hf8;
  localparam logic [7:0]  NV_HI_LAST     = 8'hfb;
  localparam int          UPD_LIVE_BIT   = 0;
  localparam int          UPD_COMMIT_BIT = 1;
  localparam int          UPD_ERASE_BIT  = 2;
  localparam int          RELOAD_BIT     = 0;
  localparam logic [7:0]  UPD_CTRL_RESET = 8'h00;
  localparam logic [7:0]  PTR_HI_RESET   = 8'h00;
  localparam int          SE_DELAY_NS    = 500000;
  localparam int          SE_DELAY_CYC   = SE_DELAY_NS / CLK_PERIOD_NS;
  localparam int          SE_FETCH_NS    = 10000;
  localparam int          SE_FETCH_CYC   = SE_FETCH_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_LOCKOUT, ST_LOAD, ST_COMMIT, ST_SE_WAIT, ST_FETCH, ST_RUN
  } cdu_state_type;
endpackage

/* tb/cdu_config_loader_props.sv */
`timescale 1ns/10ps
module cdu_config_loader_props #(
  parameter int CFG_BYTES    = cdu_pkg::CFG_BYTES,
  parameter int SE_DELAY_CYC = cdu_pkg::SE_DELAY_CYC
) (
  // Clock, reset, supply
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   supply_lockout_release_i,
  // Host link
  input wire logic                   link_clk_i,
  input wire logic                   link_sel_i,
  input wire logic [7:0]             link_data_i,
  input wire logic                   link_ack_o,
  input wire logic [7:0]             link_rdata_o,
  // Function and engine
  input wire logic [CFG_BYTES*8-1:0] cfg_live_o,
  input wire logic                   load_done_o,
  input wire logic                   se_advance_i,
  input wire logic [5:0]             se_next_i,
  input wire logic [63:0]            se_word_o,
  input wire logic                   se_load_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] since_done_q;
  logic [31:0] since_done_d;
  // Restarts on reset so a second power-up is timed afresh
  assign since_done_d = load_done_o ? since_done_q + 32'h1 : 32'h0;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) since_done_q <= 32'h0;
    else since_done_q <= since_done_d;
  end
  property p_nack; !load_done_o |-> !link_ack_o; endproperty
  a_nack: assert property (p_nack) else $error("ack before load");
  property p_lock; !supply_lockout_release_i && !load_done_o |=> !load_done_o;
  endproperty
  a_lock: assert property (p_lock) else $error("load without supply");
  property p_hold; load_done_o |=> load_done_o; endproperty
  a_hold: assert property (p_hold) else $error("load done dropped");
  property p_pause; se_load_o |-> since_done_q > SE_DELAY_CYC; endproperty
  a_pause: assert property (p_pause) else $error("state fetch early");
  property p_fetch;
    se_advance_i && since_done_q > SE_DELAY_CYC + 300 |-> ##[240:260] se_load_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch time off");
  property p_pulse; se_load_o |=> !se_load_o; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch pulse long");
  property p_ack;
    load_done_o && $rose(link_clk_i) && link_sel_i |-> ##[3:6] link_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("byte not acked");
  property p_stage; $changed(cfg_live_o) |=> load_done_o; endproperty
  a_stage: assert property (p_stage) else $error("live change early");
endmodule
bind cdu_config_loader cdu_config_loader_props #(
  .CFG_BYTES(CFG_BYTES), .SE_DELAY_CYC(SE_DELAY_CYC)) u_props (.*);

/* tb/cdu_config_loader_tb_top.sv */
`timescale 1ns/10ps
module cdu_config_loader_tb_top;
  import cdu_pkg::*;
  localparam int DLY = 20;
  logic          clk_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          lock = 1'b0;
  logic          adv = 1'b0;
  logic [5:0]    nxt = 6'h00;
  logic          lclk;
  logic          lsel;
  logic [7:0]    ldat;
  logic          ack_o;
  logic [7:0]    rdat;
  logic [1791:0] live;
  logic          done;
  logic          se_ld;
  logic [63:0]   sew;
  logic          byte_ack;
  int            error_cnt = 0;
  int            cmp_count = 0;
  int            n;
  always #20 clk_i = ~clk_i;
  cdu_host_model u_host (.clk_i(clk_i), .link_ack_i(ack_o),
    .link_clk_o(lclk), .link_sel_o(lsel), .link_data_o(ldat));
  cdu_config_loader #(.SE_DELAY_CYC(DLY)) i_dut (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .supply_lockout_release_i(lock),
    .link_clk_i(lclk), .link_sel_i(lsel), .link_data_i(ldat),
    .link_ack_o(ack_o), .link_rdata_o(rdat), .cfg_live_o(live),
    .load_done_o(done), .se_advance_i(adv), .se_next_i(nxt),
    .se_word_o(sew), .se_load_o(se_ld));
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
    logic ack;
    u_host.open_frame();
    u_host.put(a, ack);
    chk({7'h00, ack}, {7'h00, ok});
    u_host.put(d, ack);
    chk({7'h00, ack}, {7'h00, ok});
    u_host.close_frame();
  endtask
  task automatic setp(input logic [7:0] a);
    logic ack;
    u_host.open_frame();
    u_host.put(a, ack);
    u_host.close_frame();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic power_up();
    rst_b_i = 1'b0;
    lock = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (20) @(negedge clk_i);
    chk({7'h00, done}, 8'h00);
    lock = 1'b1;
    for (n = 0; n < 1000 && done !== 1'b1; n++) @(negedge clk_i);
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic time_se();
    for (n = 0; n < 2000 && se_ld !== 1'b1; n++) @(negedge clk_i);
  endtask
  function automatic logic [7:0] lv(input int i);
    return live[8*i +: 8];
  endfunction
  initial begin
    #(40 * 30000);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    wr(8'h10, 8'h11, 1'b0);
    power_up();
    time_se();
    chk({7'h00, n > DLY && n < DLY + 270}, 8'h01);
    wr(ADDR_UPD_CTRL, 8'h01, 1'b1);
    wr(8'h10, 8'h11, 1'b1);
    chk(lv(16), 8'h11);
    wr(ADDR_UPD_CTRL, 8'h00, 1'b1);
    wr(8'h10, 8'h22, 1'b1);
    chk(lv(16), 8'h11);
    setp(8'h10);
    chk(rdat, 8'h22);
    wr(ADDR_UPD_CTRL, 8'h02, 1'b1);
    chk(lv(16), 8'h22);
    setp(ADDR_UPD_CTRL);
    chk(rdat & 8'h02, 8'h00);
    // Erase page 0, then reload it over the live bytes
    wr(ADDR_UPD_CTRL, 8'h04, 1'b1);
    wr(ADDR_ERASE, 8'h00, 1'b1);
    wr(ADDR_RELOAD, 8'h01, 1'b1);
    for (n = 0; n < 600 && lv(16) !== 8'hff; n++) @(negedge clk_i);
    chk(lv(16), 8'hff);
    // Stored byte written only after its page was erased
    wr(ADDR_PTR_HI, NV_HI_FIRST, 1'b1);
    wr(8'h10, 8'h3c, 1'b1);
    chk(lv(16), 8'hff);
    setp(8'h10);
    chk(rdat, 8'h3c);
    power_up();
    chk(lv(16), 8'h3c);
    chk(lv(17), 8'hff);
    time_se();
    // Erase enable is low after reset, so the reload must keep the byte
    wr(ADDR_ERASE, 8'h00, 1'b1);
    wr(ADDR_RELOAD, 8'h01, 1'b1);
    repeat (300) @(negedge clk_i);
    chk(lv(16), 8'h3c);
    // Erase the first state page, then write state 1 straight into it
    wr(ADDR_UPD_CTRL, 8'h04, 1'b1);
    wr(ADDR_PTR_HI, 8'h02, 1'b1);
    wr(ADDR_ERASE, 8'h00, 1'b1);
    wr(ADDR_PTR_HI, 8'hfa, 1'b1);
    u_host.open_frame();
    u_host.put(8'h08, byte_ack);
    chk({7'h00, byte_ack}, 8'h01);
    for (int k = 0; k < 8; k++) begin
      u_host.put(8'h10 + 8'(k), byte_ack);
      chk({7'h00, byte_ack}, 8'h01);
    end
    u_host.close_frame();
    @(negedge clk_i);
    nxt = 6'h01;
    adv = 1'b1;
    @(negedge clk_i);
    adv = 1'b0;
    time_se();
    chk({7'h00, n >= 240 && n <= 260}, 8'h01);
    for (int k = 0; k < 8; k++) begin
      chk(sew[8*k +: 8], 8'h10 + 8'(k));
    end
    end_sim();
  end
endmodule

/* tb/cdu_host_model.sv */
`timescale 1ns/10ps
module cdu_host_model (
  // Clock and answer
  input  wire logic       clk_i,
  input  wire logic       link_ack_i,
  // Link pins
  output logic            link_clk_o,
  output logic            link_sel_o,
  output logic [7:0]      link_data_o
);
  initial begin
    link_clk_o  = 1'b0;
    link_sel_o  = 1'b0;
    link_data_o = 8'h00;
  end
  // First byte after select is the pointer
  task automatic open_frame();
    @(negedge clk_i);
    link_sel_o = 1'b1;
  endtask
  // Link clock stands still between frames
  task automatic close_frame();
    @(negedge clk_i);
    link_sel_o = 1'b0;
  endtask
  // Eight cycle link period; data inverted once released
  task automatic put(input logic [7:0] b, output logic ack);
    link_data_o = b;
    repeat (3) @(negedge clk_i);
    link_clk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    link_clk_o = 1'b0;
    @(negedge clk_i);
    ack = link_ack_i;
    link_data_o = ~b;
  endtask
endmodule
